/* File: hw/timer3_byte_bank.sv */
// timer 3 count and capture byte registers
`timescale 1ns/1ps
`default_nettype none
`include "timer_sync_map.svh"

module timer3_byte_bank
  import timer_sync_pkg::*;
#(
  parameter int DATA_W = 8
)
(
  // clock, reset and enable
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // software access, index 0..3 = cap low, cap high, cnt low, cnt high
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  input  wire logic [1:0]        index,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [DATA_W-1:0] rdata,
  // forced reload from the capture bytes
  input  wire logic              load_high,
  input  wire logic              load_low,
  // values to the counter array
  output logic      [DATA_W-1:0] cap_low,
  output logic      [DATA_W-1:0] cap_high,
  output logic      [DATA_W-1:0] cnt_low,
  output logic      [DATA_W-1:0] cnt_high
);

  if (DATA_W != 8)
  begin
    $error("timer3_byte_bank serves byte registers only");
  end

  logic [DATA_W-1:0] mem_reg [4];

  // ==========================================
  // storage, software write wins over a reload
  // RQ13 RQ14 byte registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 4; i++)
      begin
        mem_reg[i] <= `BYTE_RESET;
      end
    end
    else if (ce)
    begin
      if (load_low)
      begin
        mem_reg[2] <= mem_reg[0];
      end
      if (load_high)
      begin
        mem_reg[3] <= mem_reg[1];
      end
      if (wr_en)
      begin
        mem_reg[index] <= wdata;
      end
    end
  end

  // ==========================================
  // registered read port
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= `BYTE_RESET;
    end
    else if (ce && rd_en)
    begin
      rdata <= mem_reg[index];
    end
  end

  assign cap_low  = mem_reg[0];
  assign cap_high = mem_reg[1];
  assign cnt_low  = mem_reg[2];
  assign cnt_high = mem_reg[3];

  // ==========================================
  // checks
  a_byte_write_lands: assert property ( // RQ14
    @(posedge mclk) disable iff (!rst_n)
    (ce && wr_en && index == 2'h3) |=> (cnt_high == $past(wdata)))
    else $error("count high byte did not take the written value");

  a_capture_readback: assert property ( // RQ13
    @(posedge mclk) disable iff (!rst_n)
    (ce && rd_en && !wr_en && !load_high && !load_low && index == 2'h1) |=> (rdata == cap_high))
    else $error("capture high byte read back wrong");

endmodule
`default_nettype wire

/* File: hw/timer_global_sync_control.sv */
// global start, reload and stop of four timers and timer 3 byte registers
`timescale 1ns/1ps
`default_nettype none
`include "timer_sync_map.svh"

module timer_global_sync_control
  import timer_sync_pkg::*;
#(
  parameter int NUM_TIMERS = 4
)
(
  // clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       ce,
  // register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic [1:0] sfr_page,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  // timer mode and low run hardware clear from the timer control logic
  input  wire logic [1:0] split_mode,
  input  wire logic [1:0] capture_mode,
  input  wire logic [1:0] low_hw_clr,
  // run controls
  output logic      [3:0] run_ctrl,
  output logic      [1:0] run_ctrl_low,
  // forced reload pulses per timer
  output logic      [3:0] reload_high,
  output logic      [3:0] reload_low,
  // timer 3 byte values
  output logic      [7:0] timer3_capture_lo,
  output logic      [7:0] timer3_capture_hi,
  output logic      [7:0] timer3_low_count,
  output logic      [7:0] timer3_high_count
);

  if (NUM_TIMERS != 4)
  begin
    $error("strobe layout serves exactly four timers");
  end

  // ==========================================
  // decode helper
  function automatic logic hit(input sfr_req_t r, input logic [7:0] a, input page_t p);
    hit = (r.addr == a) && (r.page == p);
  endfunction

  function automatic strobe_t to_strobe(input logic [7:0] d);
    to_strobe.full = d[`FULL_LSB +: 4];
    to_strobe.low2 = d[`LOW2_BIT];
    to_strobe.low3 = d[`LOW3_BIT];
  endfunction

  // ==========================================
  // reset release
  logic [1:0] rst_pipe_reg;
  logic       rst_n_s;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_pipe_reg <= 2'h0;
    end
    else
    begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end

  assign rst_n_s = rst_pipe_reg[1];

  // ==========================================
  // request decode
  sfr_req_t req;
  strobe_t  stb;
  logic     start_hit;
  logic     reload_hit;
  logic     stop_hit;
  logic     bank_wr;
  logic     bank_rd;
  logic     bank_hit;
  logic [1:0] bank_index;

  assign req = '{addr: addr, wdata: wdata, page: sfr_page, wr: wr_en, rd: rd_en};

  // RQ4 reserved bits 7 and 4 are not decoded
  assign stb = to_strobe(req.wdata);

  // RQ12 page selects the strobe register
  assign start_hit  = req.wr && hit(req, `STROBE_ADDR, `PAGE_START);
  assign reload_hit = req.wr && hit(req, `STROBE_ADDR, `PAGE_RELOAD);
  assign stop_hit   = req.wr && hit(req, `STROBE_ADDR, `PAGE_STOP);

  assign bank_hit   = (req.page == `PAGE_TIMER3)
                   && (req.addr >= `CAP3_LOW_ADDR) && (req.addr <= `CNT3_HIGH_ADDR);
  assign bank_index = 2'(req.addr - `CAP3_LOW_ADDR);
  assign bank_wr    = req.wr && bank_hit;
  assign bank_rd    = req.rd && bank_hit;

  // ==========================================
  // full timer run controls
  logic [3:0] run_reg;
  logic [3:0] run_next;

  // RQ1 RQ10 set and clear runs
  always_comb
  begin
    run_next = run_reg;
    if (start_hit)
    begin
      run_next = run_reg | stb.full;
    end
    else if (stop_hit)
    begin
      run_next = run_reg & ~stb.full;
    end
  end

  // RQ3 strobes act once, never stored
  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      run_reg <= `RUN_RESET;
    end
    else if (ce)
    begin
      run_reg <= run_next;
    end
  end

  // ==========================================
  // split low byte run controls
  logic [1:0] run_low_reg;
  logic [1:0] run_low_next;
  logic [1:0] low_set;
  logic [1:0] low_clr;

  // RQ2 RQ11 split-low start and stop
  assign low_set = {2{start_hit}} & {stb.low3, stb.low2} & split_mode;
  assign low_clr = ({2{stop_hit}} & {stb.low3, stb.low2} & split_mode) | low_hw_clr;

  // RQ15 low byte has its own run, set wins
  always_comb
  begin
    run_low_next = (run_low_reg & ~low_clr) | low_set;
  end

  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      run_low_reg <= `RUN_LOW_RESET;
    end
    else if (ce)
    begin
      run_low_reg <= run_low_next;
    end
  end

  assign run_ctrl     = run_reg;
  assign run_ctrl_low = run_low_reg;

  // ==========================================
  // forced reload pulses
  logic [3:0] rl_high_next;
  logic [3:0] rl_low_next;
  logic [3:0] rl_high_reg;
  logic [3:0] rl_low_reg;
  logic [1:0] low_stb;

  assign low_stb = {stb.low3, stb.low2};

  always_comb
  begin
    rl_high_next = 4'h0;
    rl_low_next  = 4'h0;
    if (reload_hit)
    begin
      // RQ5 timers 0 and 1 reload both bytes
      rl_high_next[1:0] = stb.full[1:0];
      rl_low_next[1:0]  = stb.full[1:0];
      for (int i = 0; i < 2; i++)
      begin
        // RQ8 capture mode blocks reloads
        if (!capture_mode[i])
        begin
          // RQ6 RQ7 full strobe, high byte always
          rl_high_next[i+2] = stb.full[i+2];
          // RQ9 split-low strobe drives the low byte
          rl_low_next[i+2]  = split_mode[i] ? low_stb[i] : stb.full[i+2];
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      rl_high_reg <= 4'h0;
      rl_low_reg  <= 4'h0;
    end
    else if (ce)
    begin
      rl_high_reg <= rl_high_next;
      rl_low_reg  <= rl_low_next;
    end
  end

  assign reload_high = rl_high_reg;
  assign reload_low  = rl_low_reg;

  // ==========================================
  // timer 3 byte registers
  logic [7:0] bank_rdata;

  timer3_byte_bank #(
    .DATA_W (8)
  ) u_bank (
    .mclk      (mclk),
    .rst_n     (rst_n_s),
    .ce        (ce),
    .wr_en     (bank_wr),
    .rd_en     (bank_rd),
    .index     (bank_index),
    .wdata     (req.wdata),
    .rdata     (bank_rdata),
    .load_high (rl_high_reg[3]),
    .load_low  (rl_low_reg[3]),
    .cap_low   (timer3_capture_lo),
    .cap_high  (timer3_capture_hi),
    .cnt_low   (timer3_low_count),
    .cnt_high  (timer3_high_count)
  );

  // ==========================================
  // read path
  logic [7:0] own_rdata_reg;
  logic       bank_sel_reg;

  // RQ16 strobe registers and unmapped read zero
  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      own_rdata_reg <= `BYTE_RESET;
      bank_sel_reg  <= 1'b0;
    end
    else if (ce)
    begin
      bank_sel_reg  <= bank_rd;
      own_rdata_reg <= `BYTE_RESET;
      if (req.rd && req.addr == `RUN_STATUS_ADDR)
      begin
        own_rdata_reg <= {1'b0, run_low_reg, 1'b0, run_reg};
      end
    end
  end

  assign rdata = bank_sel_reg ? bank_rdata : own_rdata_reg;

  // ==========================================
  // checks
  a_start_sets_run: assert property ( // RQ1
    @(posedge mclk) disable iff (!rst_n_s)
    (ce && start_hit) |=> ((run_ctrl & $past(wdata[3:0])) == $past(wdata[3:0])))
    else $error("start strobe did not set run control");

  a_low_start_split: assert property ( // RQ2
    @(posedge mclk) disable iff (!rst_n_s)
    (ce && start_hit && wdata[`LOW3_BIT] && split_mode[1]) |=> run_ctrl_low[1])
    else $error("split low start did not set timer 3 low run");

  a_zero_write_idle: assert property ( // RQ3
    @(posedge mclk) disable iff (!rst_n_s)
    (ce && wr_en && addr == `STROBE_ADDR && wdata == 8'h00) |=> ($stable(run_ctrl)
      && reload_high == 4'h0 && reload_low == 4'h0))
    else $error("zero strobe write had an effect");

  a_reload_timer0: assert property ( // RQ5
    @(posedge mclk) disable iff (!rst_n_s)
    (ce && reload_hit && wdata[0]) |=> (reload_high[0] && reload_low[0]))
    else $error("timer 0 reload missing");

  a_reload_full_t3: assert property ( // RQ6
    @(posedge mclk) disable iff (!rst_n_s)
    (ce && reload_hit && wdata[3] && !split_mode[1] && !capture_mode[1])
      |=> (reload_high[3] && reload_low[3]))
    else $error("timer 3 full reload missing");

  a_split_high_only: assert property ( // RQ7
    @(posedge mclk) disable iff (!rst_n_s)
    (ce && reload_hit && wdata[3] && !wdata[`LOW3_BIT] && split_mode[1])
      |=> (reload_low[3] == 1'b0))
    else $error("split full reload touched low byte");

  a_capture_blocks: assert property ( // RQ8
    @(posedge mclk) disable iff (!rst_n_s)
    (ce && reload_hit && capture_mode[1]) |=> (!reload_high[3] && !reload_low[3]))
    else $error("reload in capture mode");

  a_low_reload_split: assert property ( // RQ9
    @(posedge mclk) disable iff (!rst_n_s)
    (ce && reload_hit && wdata[`LOW2_BIT] && split_mode[0] && !capture_mode[0])
      |=> reload_low[2])
    else $error("timer 2 low reload missing");

  a_stop_clears_run: assert property ( // RQ10
    @(posedge mclk) disable iff (!rst_n_s)
    (ce && stop_hit) |=> ((run_ctrl & $past(wdata[3:0])) == 4'h0))
    else $error("stop strobe did not clear run control");

  a_low_stop_split: assert property ( // RQ11
    @(posedge mclk) disable iff (!rst_n_s)
    (ce && stop_hit && wdata[`LOW3_BIT] && split_mode[1]) |=> !run_ctrl_low[1])
    else $error("split low stop did not clear");

  a_page_zero_idle: assert property ( // RQ12
    @(posedge mclk) disable iff (!rst_n_s)
    (ce && wr_en && addr == `STROBE_ADDR && sfr_page == 2'h0) |=> $stable(run_ctrl))
    else $error("page 0 write reached a strobe");

  a_t3_run_high_only: assert property ( // RQ15
    @(posedge mclk) disable iff (!rst_n_s)
    (ce && start_hit && !wdata[`LOW3_BIT] && !low_hw_clr[1]) |=> $stable(run_ctrl_low[1]))
    else $error("main run start changed low byte run");

  a_strobe_reads_zero: assert property ( // RQ16
    @(posedge mclk) disable iff (!rst_n_s)
    (ce && rd_en && addr == `STROBE_ADDR) |=> (rdata == 8'h00))
    else $error("strobe register read nonzero");

endmodule
`default_nettype wire

/* File: hw/timer_sync_map.svh */
// constants and bit positions of the timer global synchronous control
//
// Function
// RQ1 - a one in a full start strobe sets that timer's run control
// RQ2 - a split-low start strobe sets the low byte run control in split mode
// RQ3 - strobe bits clear themselves; writing zero does nothing
// RQ4 - software writes zero to bits 7 and 4 of every strobe register
// RQ5 - reload strobe of timer 0 or 1 reloads both count bytes at once
// RQ6 - reload strobe of timer 2 or 3 reloads both bytes when not split
// RQ7 - in split mode the full reload strobe reloads only the high byte
// RQ8 - forced reloads of timers 2 and 3 do nothing in capture mode
// RQ9 - split-low reload strobe reloads the low count byte in split mode
// RQ10 - a one in a full stop strobe clears that timer's run control
// RQ11 - split-low stop strobe clears the low byte run control in split mode
// RQ12 - the three strobe registers share one address, chosen by page 1, 2, 3
// RQ13 - timer 3 capture low and high bytes are read/write, reset to zero
// RQ14 - timer 3 count low and high bytes are read/write, reset to zero
// RQ15 - in split mode timer 3 main run governs only the high byte
// RQ16 - strobe registers always read back as zero
`ifndef TIMER_SYNC_MAP_SVH
`define TIMER_SYNC_MAP_SVH

// ==========================================
// addresses and pages
`define STROBE_ADDR      8'h95
`define RUN_STATUS_ADDR  8'h96
`define CAP3_LOW_ADDR    8'hCA
`define CAP3_HIGH_ADDR   8'hCB
`define CNT3_LOW_ADDR    8'hCC
`define CNT3_HIGH_ADDR   8'hCD
`define PAGE_START       2'h1
`define PAGE_RELOAD      2'h2
`define PAGE_STOP        2'h3
`define PAGE_TIMER3      2'h1

// ==========================================
// strobe field positions
`define FULL_LSB         0
`define LOW2_BIT         5
`define LOW3_BIT         6

// ==========================================
// reset values
`define BYTE_RESET       8'h00
`define RUN_RESET        4'h0
`define RUN_LOW_RESET    2'h0

`endif

/* File: hw/timer_sync_pkg.sv */
// types of the timer global synchronous control
package timer_sync_pkg;

  typedef logic [1:0] page_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    page_t      page;
    logic       wr;
    logic       rd;
  } sfr_req_t;

  typedef struct packed {
    logic       low3;
    logic       low2;
    logic [3:0] full;
  } strobe_t;

endpackage

/* File: verification/timer_global_sync_control_tb.sv */
// self-checking testbench of the timer global synchronous control
`timescale 1ns/1ps
`default_nettype none
`include "timer_sync_map.svh"

module timer_global_sync_control_tb
  import timer_sync_pkg::*;
;

  // ==========================================
  // stimulus and observed signals
  logic       mclk         = 1'b0;
  logic       reset_n      = 1'b0;
  logic       ce           = 1'b1;
  logic [7:0] addr         = 8'h00;
  logic [7:0] wdata        = 8'h00;
  logic [1:0] sfr_page     = 2'h0;
  logic       wr_en        = 1'b0;
  logic       rd_en        = 1'b0;
  logic [1:0] split_mode   = 2'h0;
  logic [1:0] capture_mode = 2'h0;
  logic [1:0] low_hw_clr   = 2'h0;
  logic [7:0] rdata;
  logic [3:0] run_ctrl;
  logic [1:0] run_ctrl_low;
  logic [3:0] reload_high;
  logic [3:0] reload_low;
  logic [7:0] cap_lo;
  logic [7:0] cap_hi;
  logic [7:0] cnt_lo;
  logic [7:0] cnt_hi;
  int         error_cnt    = 0;
  int         checks       = 0;

  timer_global_sync_control #(.NUM_TIMERS(4)) dut
  (
    .mclk              (mclk),
    .reset_n           (reset_n),
    .ce                (ce),
    .addr              (addr),
    .wdata             (wdata),
    .sfr_page          (sfr_page),
    .wr_en             (wr_en),
    .rd_en             (rd_en),
    .rdata             (rdata),
    .split_mode        (split_mode),
    .capture_mode      (capture_mode),
    .low_hw_clr        (low_hw_clr),
    .run_ctrl          (run_ctrl),
    .run_ctrl_low      (run_ctrl_low),
    .reload_high       (reload_high),
    .reload_low        (reload_low),
    .timer3_capture_lo (cap_lo),
    .timer3_capture_hi (cap_hi),
    .timer3_low_count  (cnt_lo),
    .timer3_high_count (cnt_hi)
  );

  always #10 mclk = ~mclk;

  // ==========================================
  // shared tasks
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [1:0] p, input logic [7:0] d);
    @(posedge mclk);
    addr     <= a;
    sfr_page <= p;
    wdata    <= d;
    wr_en    <= 1'b1;
    @(posedge mclk);
    wr_en    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] p, input logic [7:0] exp, input string name);
    @(posedge mclk);
    addr     <= a;
    sfr_page <= p;
    rd_en    <= 1'b1;
    @(posedge mclk);
    rd_en    <= 1'b0;
    #1;
    chk(name, exp, rdata);
  endtask

  task automatic mode(input logic [1:0] s, input logic [1:0] c);
    @(posedge mclk);
    split_mode   <= s;
    capture_mode <= c;
  endtask

  task automatic chk_run(input logic [3:0] full, input logic [1:0] low);
    chk("run_ctrl", {4'h0, full}, {4'h0, run_ctrl});
    chk("run_ctrl_low", {6'h00, low}, {6'h00, run_ctrl_low});
  endtask

  task automatic chk_pulse(input logic [3:0] hi, input logic [3:0] lo);
    chk("reload_high", {4'h0, hi}, {4'h0, reload_high});
    chk("reload_low", {4'h0, lo}, {4'h0, reload_low});
  endtask

  // ==========================================
  // scenarios
  task automatic test_reset_values;
    chk_run(4'h0, 2'h0);
    rd(`CAP3_LOW_ADDR, `PAGE_TIMER3, 8'h00, "cap_low");
    rd(`CAP3_HIGH_ADDR, `PAGE_TIMER3, 8'h00, "cap_high");
    rd(`CNT3_LOW_ADDR, `PAGE_TIMER3, 8'h00, "cnt_low");
    rd(`CNT3_HIGH_ADDR, `PAGE_TIMER3, 8'h00, "cnt_high");
    for (int p = 1; p < 4; p++)
      rd(`STROBE_ADDR, 2'(p), 8'h00, "strobe_read");
    $display("test reset_values done");
  endtask

  task automatic test_run_strobes;
    wr(`STROBE_ADDR, `PAGE_START, 8'h05);
    chk_run(4'h5, 2'h0);
    wr(`STROBE_ADDR, `PAGE_START, 8'h0A);
    chk_run(4'hF, 2'h0);
    wr(`STROBE_ADDR, `PAGE_START, 8'h00);
    chk_run(4'hF, 2'h0);
    rd(`STROBE_ADDR, `PAGE_START, 8'h00, "start_read");
    rd(`RUN_STATUS_ADDR, 2'h0, 8'h0F, "run_status");
    wr(`STROBE_ADDR, `PAGE_STOP, 8'h09);
    chk_run(4'h6, 2'h0);
    wr(`STROBE_ADDR, 2'h0, 8'h0F);
    chk_run(4'h6, 2'h0);
    wr(`STROBE_ADDR, `PAGE_RELOAD, 8'h03);
    chk_run(4'h6, 2'h0);
    chk_pulse(4'h3, 4'h3);
    $display("test run_strobes done");
  endtask

  task automatic test_split_low;
    wr(`STROBE_ADDR, `PAGE_START, 8'h60);
    chk_run(4'h6, 2'h0);
    mode(2'h3, 2'h0);
    wr(`STROBE_ADDR, `PAGE_START, 8'h60);
    chk_run(4'h6, 2'h3);
    wr(`STROBE_ADDR, `PAGE_STOP, 8'h20);
    chk_run(4'h6, 2'h2);
    wr(`STROBE_ADDR, `PAGE_START, 8'h08);
    chk_run(4'hE, 2'h2);
    wr(`STROBE_ADDR, `PAGE_STOP, 8'h08);
    chk_run(4'h6, 2'h2);
    @(posedge mclk);
    low_hw_clr <= 2'h2;
    @(posedge mclk);
    low_hw_clr <= 2'h0;
    #1;
    chk_run(4'h6, 2'h0);
    $display("test split_low done");
  endtask

  task automatic test_reload;
    mode(2'h0, 2'h0);
    wr(`CAP3_LOW_ADDR, `PAGE_TIMER3, 8'h34);
    wr(`CAP3_HIGH_ADDR, `PAGE_TIMER3, 8'h12);
    wr(`CNT3_LOW_ADDR, `PAGE_TIMER3, 8'h56);
    wr(`CNT3_HIGH_ADDR, `PAGE_TIMER3, 8'h78);
    wr(`STROBE_ADDR, `PAGE_RELOAD, 8'h0F);
    chk_pulse(4'hF, 4'hF);
    @(posedge mclk);
    #1;
    chk_pulse(4'h0, 4'h0);
    chk("cnt_low", 8'h34, cnt_lo);
    chk("cnt_high", 8'h12, cnt_hi);
    mode(2'h3, 2'h0);
    wr(`CNT3_LOW_ADDR, `PAGE_TIMER3, 8'hAA);
    wr(`CNT3_HIGH_ADDR, `PAGE_TIMER3, 8'hBB);
    wr(`STROBE_ADDR, `PAGE_RELOAD, 8'h0C);
    chk_pulse(4'hC, 4'h0);
    @(posedge mclk);
    #1;
    chk("cnt_low", 8'hAA, cnt_lo);
    chk("cnt_high", 8'h12, cnt_hi);
    wr(`STROBE_ADDR, `PAGE_RELOAD, 8'h60);
    chk_pulse(4'h0, 4'hC);
    @(posedge mclk);
    #1;
    chk("cnt_low", 8'h34, cnt_lo);
    mode(2'h0, 2'h0);
    wr(`STROBE_ADDR, `PAGE_RELOAD, 8'h60);
    chk_pulse(4'h0, 4'h0);
    mode(2'h3, 2'h3);
    wr(`STROBE_ADDR, `PAGE_RELOAD, 8'h6F);
    chk_pulse(4'h3, 4'h3);
    mode(2'h0, 2'h0);
    $display("test reload done");
  endtask

  task automatic test_byte_regs;
    wr(`CNT3_HIGH_ADDR, `PAGE_TIMER3, 8'hA5);
    rd(`CNT3_HIGH_ADDR, `PAGE_TIMER3, 8'hA5, "cnt_high");
    chk("cnt_high_out", 8'hA5, cnt_hi);
    wr(`CNT3_LOW_ADDR, `PAGE_TIMER3, 8'h3C);
    rd(`CNT3_LOW_ADDR, `PAGE_TIMER3, 8'h3C, "cnt_low");
    wr(`CAP3_LOW_ADDR, `PAGE_TIMER3, 8'h5A);
    rd(`CAP3_LOW_ADDR, `PAGE_TIMER3, 8'h5A, "cap_low");
    chk("cap_low_out", 8'h5A, cap_lo);
    wr(`CAP3_HIGH_ADDR, `PAGE_TIMER3, 8'hC3);
    rd(`CAP3_HIGH_ADDR, `PAGE_TIMER3, 8'hC3, "cap_high");
    chk("cap_high_out", 8'hC3, cap_hi);
    rd(8'h10, `PAGE_TIMER3, 8'h00, "unmapped");
    $display("test byte_regs done");
  endtask

  task automatic test_freeze_reset;
    @(posedge mclk);
    ce <= 1'b0;
    wr(`STROBE_ADDR, `PAGE_START, 8'h0F);
    wr(`CNT3_HIGH_ADDR, `PAGE_TIMER3, 8'h99);
    chk_run(4'h6, 2'h0);
    chk("cnt_high_frozen", 8'hA5, cnt_hi);
    @(posedge mclk);
    ce      <= 1'b1;
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk_run(4'h0, 2'h0);
    chk_pulse(4'h0, 4'h0);
    chk("cnt_high_reset", 8'h00, cnt_hi);
    chk("cnt_low_reset", 8'h00, cnt_lo);
    chk("cap_low_reset", 8'h00, cap_lo);
    chk("cap_high_reset", 8'h00, cap_hi);
    wr(`STROBE_ADDR, `PAGE_START, 8'h01);
    chk_run(4'h1, 2'h0);
    $display("test freeze_reset done");
  endtask

  // ==========================================
  // main sequence and watchdog
  initial
  begin
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    test_reset_values();
    test_run_strobes();
    test_split_low();
    test_reload();
    test_byte_regs();
    test_freeze_reset();
    test_done();
  end

  initial
  begin
    #50000;
    error_cnt++;
    test_done();
  end

endmodule

`default_nettype wire
